/* File: common/mim_pkg.sv */
// shared constants, types and helpers for the monitor mask and auxiliary registers
package mim_pkg;
    localparam logic [6:0] ADDR_MGMT_MASK_LOW = 7'h43;
    localparam logic [6:0] ADDR_MGMT_MASK_HIGH = 7'h44;
    localparam logic [6:0] ADDR_HOST_MASK_LOW = 7'h45;
    localparam logic [6:0] ADDR_HOST_MASK_HIGH = 7'h46;
    localparam logic [6:0] ADDR_VID_DIVISOR = 7'h47;
    localparam logic [6:0] ADDR_SERIAL_ADDRESS = 7'h48;

    localparam logic [7:0] RST_MGMT_MASK_LOW = 8'h00;
    localparam logic [7:0] RST_MGMT_MASK_HIGH = 8'h00;
    localparam logic [7:0] RST_HOST_MASK_LOW = 8'h00;
    localparam logic [6:0] RST_HOST_MASK_HIGH = 7'h40;
    localparam logic [3:0] RST_DIVISOR_FIELD = 4'h5;
    localparam logic [6:0] RST_SERIAL_ADDRESS = 7'h2d;

    localparam int POS_RESET_PERMIT = 7;
    localparam int POS_CHASSIS_CLEAR = 7;
    localparam int POS_VID = 0;
    localparam int POS_TACH_1_DIV = 4;
    localparam int POS_TACH_2_DIV = 6;

    localparam int unsigned CLOCK_HZ = 20000000;
    localparam int unsigned PULSE_MS = 20;
    // least time: exact here, so no rounding needed
    localparam int unsigned PULSE_CYCLES = (CLOCK_HZ / 1000) * PULSE_MS;

    typedef enum logic [1:0] {
        MIM_IDLE = 2'b01,
        MIM_PULSE = 2'b10
    } mim_pulse_state_t;

    typedef struct packed {
        logic [6:0] high;
        logic [7:0] low;
    } mim_status_t;

    typedef struct packed {
        logic mgmt_en;
        logic host_en;
        logic nmi_sel;
        logic int_clear;
    } mim_cfg_t;

    function automatic logic mim_reg_hit(input logic [6:0] addr, input logic [6:0] target);
        mim_reg_hit = (addr == target);
    endfunction : mim_reg_hit

    function automatic logic mim_any_set(input logic [14:0] v);
        mim_any_set = |v;
    endfunction : mim_any_set
endpackage : mim_pkg

/* File: hw/mim_pulse_timer.sv */
// fixed-length active-low pulse generator with end-of-pulse strobe
`timescale 1ns/10ps
module mim_pulse_timer #(
    parameter int unsigned CYCLES = mim_pkg::PULSE_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic start,
    output logic pulse_n,
    output logic drive,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    mim_pkg::mim_pulse_state_t state_q, state_d;
    logic [CW-1:0] count_q, count_d;
    logic pulse_n_q, pulse_n_d, drive_q, drive_d, done_q, done_d;

    always_comb
    begin
        state_d = state_q;
        count_d = count_q;
        done_d = 1'b0;
        case (state_q)
            mim_pkg::MIM_IDLE:
            begin
                // a start here is accepted, so a request landing on the done cycle is kept
                if (start)
                begin
                    state_d = mim_pkg::MIM_PULSE;
                    count_d = '0;
                end
            end
            mim_pkg::MIM_PULSE:
            begin
                if (count_q == LAST)
                begin
                    state_d = mim_pkg::MIM_IDLE;
                    done_d = 1'b1;
                end
                else
                begin
                    count_d = count_q + 1'b1;
                end
            end
            default:
            begin
                state_d = mim_pkg::MIM_IDLE;
            end
        endcase
        drive_d = (state_d == mim_pkg::MIM_PULSE);
        pulse_n_d = !drive_d;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= mim_pkg::MIM_IDLE;
            count_q <= '0;
            pulse_n_q <= 1'b1;
            drive_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            count_q <= count_d;
            pulse_n_q <= pulse_n_d;
            drive_q <= drive_d;
            done_q <= done_d;
        end
    end

    assign pulse_n = pulse_n_q;
    assign drive = drive_q;
    assign done = done_q;

    logic [CW:0] low_run_q;
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            low_run_q <= '0;
        else if (!pulse_n_q)
            low_run_q <= low_run_q + 1'b1;
        else
            low_run_q <= '0;
    end

    pulse_width_a: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(pulse_n_q) |-> (low_run_q == (CW+1)'(CYCLES)))
        else $error("pulse length differs from the programmed count");
    start_low_a: assert property (@(posedge clock) disable iff (!reset_n)
        start && pulse_n_q |=> !pulse_n_q && drive_q)
        else $error("pulse did not start one cycle after request");
    done_end_a: assert property (@(posedge clock) disable iff (!reset_n)
        done_q |-> !$past(pulse_n_q))
        else $error("done strobe without a preceding pulse");
endmodule : mim_pulse_timer

/* File: hw/mim_irq_route.sv */
// gates latched status through a mask onto one registered interrupt pin
`timescale 1ns/10ps
module mim_irq_route (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [14:0] status,
    input wire logic [14:0] mask,
    input wire logic enable,
    input wire logic active_high,
    output logic irq_out
);
    logic [14:0] gated;
    logic fire;
    logic irq_q, irq_d;

    genvar i;
    generate
        for (i = 0; i < 15; i++)
        begin : g_gate
            // the mask only steers routing; status itself stays untouched
            assign gated[i] = status[i] & ~mask[i];
        end
    endgenerate

    always_comb
    begin
        fire = enable && mim_pkg::mim_any_set(gated);
        irq_d = active_high ? fire : !fire;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            irq_q <= 1'b1;
        else
            irq_q <= irq_d;
    end

    assign irq_out = irq_q;

    disabled_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
        !enable |=> (irq_q == !$past(active_high)))
        else $error("interrupt driven while disabled");
    masked_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
        ((status & ~mask) == 15'h0000) |=> (irq_q == !$past(active_high)))
        else $error("fully masked status still raised an interrupt");
endmodule : mim_irq_route

/* File: hw/mim_irq_mask_regs.sv */
// interrupt masks, divisor, address registers with reset and chassis-clear pulses
// What this block does
// - register 43h masks low status sources from the management interrupt
// - register 44h bits 6:0 mask high status sources from management interrupt
// - register 45h masks low status sources from the host interrupt
// - register 46h bits 6:0 mask high status sources from host interrupt
// - masks 43h, 44h, 45h reset to zero
// - mask 46h resets to 40h, chained input masked from host interrupt
// - bit 7 of 44h permits the configuration reset pulse
// - writing one to 46h bit 7 pulses chassis pin low 20 ms, self-clears
// - 47h bits 3:0 read the voltage-id inputs, read-only
// - 47h bits 5:4 pick tach_1 divisor 1, 2, 4 or 8
// - 47h bits 7:6 pick tach_2 divisor 1, 2, 4 or 8
// - 47h bits 7:4 reset to 0101, both divisors by two
// - 48h holds 7-bit serial address, default 2Dh, bit 7 reads zero
// - each interrupt output works only while its enable bit is set
// - a configuration bit picks NMI or IRQ signalling for host output
// - configuration reset with permit set drives reset low 20 ms, self-clears
// - status bits are latched limit violations from outside this block
`timescale 1ns/10ps
module mim_irq_mask_regs #(
    parameter int unsigned PULSE_CYCLES = mim_pkg::PULSE_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    input wire mim_pkg::mim_status_t status,
    input wire mim_pkg::mim_cfg_t cfg,
    input wire logic cfg_reset_write,
    input wire logic [3:0] cpu_voltage_id,
    output logic mgmt_irq_out_n,
    output logic host_irq_out,
    output logic cfg_reset_bit,
    output logic reset_out_n,
    output logic chassis_pin_o,
    output logic chassis_pin_oe,
    output logic reset_pulse_permit,
    output logic [1:0] tach_1_div,
    output logic [1:0] tach_2_div,
    output logic [6:0] serial_address
);
    logic [7:0] mgmt_mask_low_q, mgmt_mask_low_d;
    logic [7:0] mgmt_mask_high_q, mgmt_mask_high_d;
    logic [7:0] host_mask_low_q, host_mask_low_d;
    logic [6:0] host_mask_high_q, host_mask_high_d;
    logic chassis_clear_q, chassis_clear_d;
    logic cfg_reset_bit_q, cfg_reset_bit_d;
    logic [3:0] divisor_q, divisor_d;
    logic [6:0] serial_address_q, serial_address_d;
    logic [7:0] rdata_q, rdata_d;
    logic hit_q, hit_d;

    logic wr_mgmt_low, wr_mgmt_high, wr_host_low, wr_host_high, wr_div, wr_addr;
    logic chassis_start, reset_start;
    logic chassis_pulse_n, chassis_drive, chassis_done;
    logic reset_pulse_n, reset_done;

    always_comb
    begin
        wr_mgmt_low = reg_wr && mim_pkg::mim_reg_hit(reg_addr, mim_pkg::ADDR_MGMT_MASK_LOW);
        wr_mgmt_high = reg_wr && mim_pkg::mim_reg_hit(reg_addr, mim_pkg::ADDR_MGMT_MASK_HIGH);
        wr_host_low = reg_wr && mim_pkg::mim_reg_hit(reg_addr, mim_pkg::ADDR_HOST_MASK_LOW);
        wr_host_high = reg_wr && mim_pkg::mim_reg_hit(reg_addr, mim_pkg::ADDR_HOST_MASK_HIGH);
        wr_div = reg_wr && mim_pkg::mim_reg_hit(reg_addr, mim_pkg::ADDR_VID_DIVISOR);
        wr_addr = reg_wr && mim_pkg::mim_reg_hit(reg_addr, mim_pkg::ADDR_SERIAL_ADDRESS);
        // a write of one while the pulse runs is absorbed by the running pulse
        chassis_start = wr_host_high && reg_wdata[mim_pkg::POS_CHASSIS_CLEAR];
        // without the permit bit the command is dropped and the bit never sets
        reset_start = cfg_reset_write && mgmt_mask_high_q[mim_pkg::POS_RESET_PERMIT];
    end

    always_comb
    begin
        mgmt_mask_low_d = wr_mgmt_low ? reg_wdata : mgmt_mask_low_q;
        mgmt_mask_high_d = wr_mgmt_high ? reg_wdata : mgmt_mask_high_q;
        host_mask_low_d = wr_host_low ? reg_wdata : host_mask_low_q;
        host_mask_high_d = wr_host_high ? reg_wdata[6:0] : host_mask_high_q;
        divisor_d = wr_div ? reg_wdata[7:4] : divisor_q;
        serial_address_d = wr_addr ? reg_wdata[6:0] : serial_address_q;
        // set wins over the end-of-pulse clear
        if (chassis_start)
            chassis_clear_d = 1'b1;
        else if (chassis_done)
            chassis_clear_d = 1'b0;
        else
            chassis_clear_d = chassis_clear_q;
        if (reset_start)
            cfg_reset_bit_d = 1'b1;
        else if (reset_done)
            cfg_reset_bit_d = 1'b0;
        else
            cfg_reset_bit_d = cfg_reset_bit_q;
    end

    always_comb
    begin
        hit_d = hit_q;
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            hit_d = 1'b1;
            case (reg_addr)
                mim_pkg::ADDR_MGMT_MASK_LOW: rdata_d = mgmt_mask_low_q;
                mim_pkg::ADDR_MGMT_MASK_HIGH: rdata_d = mgmt_mask_high_q;
                mim_pkg::ADDR_HOST_MASK_LOW: rdata_d = host_mask_low_q;
                mim_pkg::ADDR_HOST_MASK_HIGH: rdata_d = {chassis_clear_q, host_mask_high_q};
                // voltage-id is sampled live, never stored
                mim_pkg::ADDR_VID_DIVISOR: rdata_d = {divisor_q, cpu_voltage_id};
                mim_pkg::ADDR_SERIAL_ADDRESS: rdata_d = {1'b0, serial_address_q};
                default:
                begin
                    rdata_d = 8'h00;
                    hit_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mgmt_mask_low_q <= mim_pkg::RST_MGMT_MASK_LOW;
            mgmt_mask_high_q <= mim_pkg::RST_MGMT_MASK_HIGH;
            host_mask_low_q <= mim_pkg::RST_HOST_MASK_LOW;
            host_mask_high_q <= mim_pkg::RST_HOST_MASK_HIGH;
            chassis_clear_q <= 1'b0;
            cfg_reset_bit_q <= 1'b0;
            divisor_q <= mim_pkg::RST_DIVISOR_FIELD;
            serial_address_q <= mim_pkg::RST_SERIAL_ADDRESS;
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end
        else
        begin
            mgmt_mask_low_q <= mgmt_mask_low_d;
            mgmt_mask_high_q <= mgmt_mask_high_d;
            host_mask_low_q <= host_mask_low_d;
            host_mask_high_q <= host_mask_high_d;
            chassis_clear_q <= chassis_clear_d;
            cfg_reset_bit_q <= cfg_reset_bit_d;
            divisor_q <= divisor_d;
            serial_address_q <= serial_address_d;
            rdata_q <= rdata_d;
            hit_q <= hit_d;
        end
    end

    mim_pulse_timer #(
        .CYCLES(PULSE_CYCLES)
    ) u_chassis_timer (
        .clock(clock),
        .reset_n(reset_n),
        .start(chassis_start),
        .pulse_n(chassis_pulse_n),
        .drive(chassis_drive),
        .done(chassis_done)
    );

    mim_pulse_timer #(
        .CYCLES(PULSE_CYCLES)
    ) u_reset_timer (
        .clock(clock),
        .reset_n(reset_n),
        .start(reset_start),
        .pulse_n(reset_pulse_n),
        .drive(),
        .done(reset_done)
    );

    // status arrives already latched from the limit comparators
    mim_irq_route u_mgmt_route (
        .clock(clock),
        .reset_n(reset_n),
        .status(status),
        .mask({mgmt_mask_high_q[6:0], mgmt_mask_low_q}),
        .enable(cfg.mgmt_en && !cfg.int_clear),
        .active_high(1'b0),
        .irq_out(mgmt_irq_out_n)
    );

    mim_irq_route u_host_route (
        .clock(clock),
        .reset_n(reset_n),
        .status(status),
        .mask({host_mask_high_q, host_mask_low_q}),
        .enable(cfg.host_en && !cfg.int_clear),
        .active_high(cfg.nmi_sel),
        .irq_out(host_irq_out)
    );

    assign reg_rdata = rdata_q;
    assign reg_hit = hit_q;
    assign cfg_reset_bit = cfg_reset_bit_q;
    assign reset_out_n = reset_pulse_n;
    assign chassis_pin_o = chassis_pulse_n;
    assign chassis_pin_oe = chassis_drive;
    assign reset_pulse_permit = mgmt_mask_high_q[mim_pkg::POS_RESET_PERMIT];
    assign tach_1_div = divisor_q[mim_pkg::POS_TACH_1_DIV-4 +: 2];
    assign tach_2_div = divisor_q[mim_pkg::POS_TACH_2_DIV-4 +: 2];
    assign serial_address = serial_address_q;

    // sources left open by each mask pair, for the checks below
    logic [14:0] mgmt_open, host_open;
    assign mgmt_open = status & ~{mgmt_mask_high_q[6:0], mgmt_mask_low_q};
    assign host_open = status & ~{host_mask_high_q, host_mask_low_q};

    sequence chassis_cmd_s;
        reg_wr && (reg_addr == mim_pkg::ADDR_HOST_MASK_HIGH) && reg_wdata[7] && !chassis_drive;
    endsequence

    sequence chassis_pulse_s;
        chassis_clear_q && chassis_pin_oe && !chassis_pin_o;
    endsequence

    sequence mgmt_high_wr_s;
        wr_mgmt_high ##1 !reg_wr;
    endsequence

    sequence mgmt_high_rd_s;
        reg_rd && (reg_addr == mim_pkg::ADDR_MGMT_MASK_HIGH) && !reg_wr;
    endsequence

    sequence reset_release_s;
        $rose(reset_out_n) && !reset_start;
    endsequence

    mgmt_low_wr_a: assert property (@(posedge clock) disable iff (!reset_n)
        wr_mgmt_low |=> (mgmt_mask_low_q == $past(reg_wdata)))
        else $error("management low mask did not take the write");
    mgmt_high_wr_a: assert property (@(posedge clock) disable iff (!reset_n)
        mgmt_high_wr_s ##1 mgmt_high_rd_s
        |=> (reg_rdata == $past(reg_wdata, 3)))
        else $error("management high mask reads back wrong");
    host_low_wr_a: assert property (@(posedge clock) disable iff (!reset_n)
        wr_host_low |=> (host_mask_low_q == $past(reg_wdata)))
        else $error("host low mask did not take the write");
    host_high_wr_a: assert property (@(posedge clock) disable iff (!reset_n)
        wr_host_high |=> (host_mask_high_q == $past(reg_wdata[6:0])))
        else $error("host high mask did not take the write");
    reset_masks_a: assert property (@(posedge clock)
        $rose(reset_n) |-> (mgmt_mask_low_q == 8'h00) && (host_mask_low_q == 8'h00)
            && (host_mask_high_q == 7'h40) && (divisor_q == 4'h5))
        else $error("mask or divisor reset value wrong");
    permit_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
        cfg_reset_write && !reset_pulse_permit && !cfg_reset_bit_q
        |=> !cfg_reset_bit_q && reset_out_n)
        else $error("reset pulse started without permit");
    reset_cmd_a: assert property (@(posedge clock) disable iff (!reset_n)
        cfg_reset_write && reset_pulse_permit && reset_out_n |=> cfg_reset_bit_q && !reset_out_n)
        else $error("permitted reset command did not start a pulse");
    reset_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        !reset_out_n |-> cfg_reset_bit_q)
        else $error("configuration reset bit cleared while pulse active");
    chassis_start_a: assert property (@(posedge clock) disable iff (!reset_n)
        chassis_cmd_s |=> chassis_pulse_s)
        else $error("chassis clear did not start the pulse");
    chassis_self_a: assert property (@(posedge clock) disable iff (!reset_n)
        chassis_done && !chassis_start |=> !chassis_clear_q)
        else $error("chassis clear bit did not self-clear");
    vid_read_a: assert property (@(posedge clock) disable iff (!reset_n)
        reg_rd && (reg_addr == mim_pkg::ADDR_VID_DIVISOR)
        |=> (reg_rdata[3:0] == $past(cpu_voltage_id)))
        else $error("voltage-id bits read back wrong");
    divisor_wr_a: assert property (@(posedge clock) disable iff (!reset_n)
        wr_div |=> (tach_1_div == $past(reg_wdata[5:4])) && (tach_2_div == $past(reg_wdata[7:6])))
        else $error("fan divisor fields not written");
    address_top_a: assert property (@(posedge clock) disable iff (!reset_n)
        reg_rd && (reg_addr == mim_pkg::ADDR_SERIAL_ADDRESS)
        |=> !reg_rdata[7] && (reg_rdata[6:0] == $past(serial_address_q)))
        else $error("serial address read back wrong");

    mgmt_fire_a: assert property (@(posedge clock) disable iff (!reset_n)
        cfg.mgmt_en && !cfg.int_clear && (mgmt_open != 15'h0000) |=> !mgmt_irq_out_n)
        else $error("management interrupt not raised");
    host_fire_a: assert property (@(posedge clock) disable iff (!reset_n)
        cfg.host_en && !cfg.int_clear && (host_open != 15'h0000)
        |=> (host_irq_out == $past(cfg.nmi_sel)))
        else $error("host interrupt not raised");
    permit_bit_a: assert property (@(posedge clock) disable iff (!reset_n)
        wr_mgmt_high |=> (reset_pulse_permit == $past(reg_wdata[7])))
        else $error("permit bit not written");
    serial_wr_a: assert property (@(posedge clock) disable iff (!reset_n)
        wr_addr |=> (serial_address == $past(reg_wdata[6:0])))
        else $error("serial address not written");
    chassis_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        chassis_pin_oe |-> chassis_clear_q && !chassis_pin_o)
        else $error("chassis pin driven without clear bit");
    reset_aux_a: assert property (@(posedge clock)
        $rose(reset_n) |-> (mgmt_mask_high_q == 8'h00) && (serial_address_q == 7'h2d)
            && !chassis_clear_q && !cfg_reset_bit_q)
        else $error("auxiliary reset value wrong");
    reset_cleared_a: assert property (@(posedge clock) disable iff (!reset_n)
        reset_release_s |=> !cfg_reset_bit_q)
        else $error("reset bit did not self-clear");
endmodule : mim_irq_mask_regs

/* File: tb/mim_host_model.sv */
// host-side partner: configuration register image and the pulled-up chassis wire
`timescale 1ns/10ps
module mim_host_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_wdata,
    input wire logic chassis_pin_o,
    input wire logic chassis_pin_oe,
    output mim_pkg::mim_cfg_t cfg,
    output logic cfg_reset_write,
    output logic chassis_level
);
    mim_pkg::mim_cfg_t cfg_q;
    mim_pkg::mim_cfg_t cfg_d;

    always_comb
    begin
        cfg_d = cfg_q;
        if (cfg_wr)
        begin
            cfg_d.mgmt_en = cfg_wdata[1];
            cfg_d.host_en = cfg_wdata[2];
            cfg_d.nmi_sel = cfg_wdata[5];
            cfg_d.int_clear = cfg_wdata[3];
        end
    end

    // power-on image has the clear bit set, so outputs stay quiet until software acts
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_q <= 4'b0001;
        end
        else
        begin
            cfg_q <= cfg_d;
        end
    end

    assign cfg = cfg_q;
    // one-shot command; the pending state lives on the device side
    assign cfg_reset_write = cfg_wr & cfg_wdata[4];
    // released wire floats to the pull-up, never keeps the last driven value
    assign chassis_level = chassis_pin_oe ? chassis_pin_o : 1'b1;
endmodule : mim_host_model

/* File: tb/monitor_irq_mask_and_aux_regs_tb_top.sv */
// self-checking bench for the interrupt mask and auxiliary registers
`timescale 1ns/10ps
module monitor_irq_mask_and_aux_regs_tb_top;
    localparam int unsigned PULSE = 8;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_hit;
    mim_pkg::mim_status_t status = 15'h0000;
    mim_pkg::mim_cfg_t cfg;
    logic cfg_reset_write;
    logic [3:0] cpu_voltage_id = 4'ha;
    logic mgmt_irq_out_n;
    logic host_irq_out;
    logic cfg_reset_bit;
    logic reset_out_n;
    logic chassis_pin_o;
    logic chassis_pin_oe;
    logic chassis_level;
    logic reset_pulse_permit;
    logic [1:0] tach_1_div;
    logic [1:0] tach_2_div;
    logic [6:0] serial_address;
    logic cfg_wr = 1'b0;
    logic [7:0] cfg_wdata = 8'h00;
    int miscompares = 0;
    int comparisons = 0;
    int n;

    always #25 clock = ~clock;

    mim_irq_mask_regs #(.PULSE_CYCLES(PULSE)) i_mim_irq_mask_regs (
        .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .status(status), .cfg(cfg), .cfg_reset_write(cfg_reset_write),
        .cpu_voltage_id(cpu_voltage_id), .mgmt_irq_out_n(mgmt_irq_out_n),
        .host_irq_out(host_irq_out), .cfg_reset_bit(cfg_reset_bit), .reset_out_n(reset_out_n),
        .chassis_pin_o(chassis_pin_o), .chassis_pin_oe(chassis_pin_oe),
        .reset_pulse_permit(reset_pulse_permit), .tach_1_div(tach_1_div),
        .tach_2_div(tach_2_div), .serial_address(serial_address)
    );

    mim_host_model i_mim_host_model (
        .clock(clock), .reset_n(reset_n), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .chassis_pin_o(chassis_pin_o), .chassis_pin_oe(chassis_pin_oe), .cfg(cfg),
        .cfg_reset_write(cfg_reset_write), .chassis_level(chassis_level)
    );

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask : wr

    // read data is registered, so it is settled at the next falling edge
    task automatic rd(input logic [6:0] a, input logic [7:0] exp, input logic hit);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        chk8(reg_rdata, exp);
        chk1(reg_hit, hit);
    endtask : rd

    task automatic cfg_write(input logic [7:0] d);
        @(negedge clock);
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge clock);
        cfg_wr = 1'b0;
    endtask : cfg_write

    // config register adds one stage ahead of the registered interrupt pins
    task automatic settle();
        repeat (3) @(negedge clock);
    endtask : settle

    task automatic count_low(input logic sel_reset, output int cnt);
        cnt = 0;
        while (cnt < 40 && (sel_reset ? reset_out_n : chassis_level) === 1'b0)
        begin
            cnt++;
            @(negedge clock);
        end
    endtask : count_low

    task automatic irq_chk(input logic mgmt_n, input logic host);
        settle();
        chk1(mgmt_irq_out_n, mgmt_n);
        chk1(host_irq_out, host);
    endtask : irq_chk

    task automatic complete_run();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20) @(negedge clock);
        reset_n = 1'b1;
        rd(mim_pkg::ADDR_MGMT_MASK_LOW, 8'h00, 1'b1);
        rd(mim_pkg::ADDR_MGMT_MASK_HIGH, 8'h00, 1'b1);
        rd(mim_pkg::ADDR_HOST_MASK_LOW, 8'h00, 1'b1);
        rd(mim_pkg::ADDR_HOST_MASK_HIGH, 8'h40, 1'b1);
        rd(mim_pkg::ADDR_VID_DIVISOR, 8'h5a, 1'b1);
        rd(mim_pkg::ADDR_SERIAL_ADDRESS, 8'h2d, 1'b1);
        rd(7'h40, 8'h00, 1'b0);
        chk1(reset_out_n, 1'b1);
        chk1(chassis_pin_oe, 1'b0);
        cpu_voltage_id = 4'h3;
        wr(mim_pkg::ADDR_VID_DIVISOR, 8'hff);
        rd(mim_pkg::ADDR_VID_DIVISOR, 8'hf3, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            wr(mim_pkg::ADDR_VID_DIVISOR, {~k[1:0], k[1:0], 4'h0});
            chk8({6'h00, tach_1_div}, {6'h00, k[1:0]});
            chk8({6'h00, tach_2_div}, {6'h00, ~k[1:0]});
            rd(mim_pkg::ADDR_VID_DIVISOR, {~k[1:0], k[1:0], 4'h3}, 1'b1);
        end
        wr(mim_pkg::ADDR_SERIAL_ADDRESS, 8'hff);
        rd(mim_pkg::ADDR_SERIAL_ADDRESS, 8'h7f, 1'b1);
        chk8({1'b0, serial_address}, 8'h7f);
        wr(mim_pkg::ADDR_MGMT_MASK_LOW, 8'ha5);
        rd(mim_pkg::ADDR_MGMT_MASK_LOW, 8'ha5, 1'b1);
        wr(mim_pkg::ADDR_HOST_MASK_LOW, 8'h5a);
        rd(mim_pkg::ADDR_HOST_MASK_LOW, 8'h5a, 1'b1);
        wr(mim_pkg::ADDR_MGMT_MASK_HIGH, 8'h3c);
        rd(mim_pkg::ADDR_MGMT_MASK_HIGH, 8'h3c, 1'b1);
        cfg_write(8'h26);
        // each source alone: unmasked fires both pins, its own mask bit silences it
        for (int i = 0; i < 15; i++)
        begin
            wr(mim_pkg::ADDR_MGMT_MASK_LOW, 8'h00);
            wr(mim_pkg::ADDR_MGMT_MASK_HIGH, 8'h00);
            wr(mim_pkg::ADDR_HOST_MASK_LOW, 8'h00);
            wr(mim_pkg::ADDR_HOST_MASK_HIGH, 8'h00);
            status = 15'h0001 << i;
            irq_chk(1'b0, 1'b1);
            wr(i < 8 ? mim_pkg::ADDR_MGMT_MASK_LOW : mim_pkg::ADDR_MGMT_MASK_HIGH,
               8'h01 << (i % 8));
            wr(i < 8 ? mim_pkg::ADDR_HOST_MASK_LOW : mim_pkg::ADDR_HOST_MASK_HIGH,
               8'h01 << (i % 8));
            irq_chk(1'b1, 1'b0);
        end
        status = 15'h0001;
        cfg_write(8'h06);
        irq_chk(1'b0, 1'b0);
        cfg_write(8'h0e);
        irq_chk(1'b1, 1'b1);
        cfg_write(8'h04);
        irq_chk(1'b1, 1'b0);
        cfg_write(8'h02);
        irq_chk(1'b0, 1'b1);
        wr(mim_pkg::ADDR_HOST_MASK_HIGH, 8'h80);
        rd(mim_pkg::ADDR_HOST_MASK_HIGH, 8'h80, 1'b1);
        chk1(chassis_pin_oe, 1'b1);
        count_low(1'b0, n);
        chk8(8'(n), 8'(PULSE - 2));
        rd(mim_pkg::ADDR_HOST_MASK_HIGH, 8'h00, 1'b1);
        wr(mim_pkg::ADDR_MGMT_MASK_HIGH, 8'h00);
        cfg_write(8'h10);
        settle();
        chk1(reset_out_n, 1'b1);
        chk1(cfg_reset_bit, 1'b0);
        wr(mim_pkg::ADDR_MGMT_MASK_HIGH, 8'h80);
        chk1(reset_pulse_permit, 1'b1);
        cfg_write(8'h10);
        chk1(cfg_reset_bit, 1'b1);
        count_low(1'b1, n);
        chk8(8'(n), 8'(PULSE));
        @(negedge clock);
        chk1(cfg_reset_bit, 1'b0);
        complete_run();
    end

    // whole sequence needs well under two thousand cycles
    initial
    begin
        #200000;
        miscompares++;
        complete_run();
    end
endmodule : monitor_irq_mask_and_aux_regs_tb_top
